// ===== verilog/iosp_pkg.sv
// Purpose: shared constants and types of the interpolator output and serial port
// Assumes: oscillator clock domain plus a serial clock domain
// Notes: all widths fixed; field layouts are packed structs
package iosp_pkg;
    localparam int CNT_W = 28;
    localparam int WORD_W = 16;
    localparam logic [19:0] SPEED_LIMIT_CYC = 20'h00060;
    localparam logic [11:0] FILTER_SPACING = 12'h800;
    localparam logic [11:0] IDLE_SATURATE = 12'h7FF;
    localparam logic [7:0] BACKLOG_LIMIT = 8'h64;
    localparam logic [1:0] OP_RESERVED = 2'h0;
    localparam logic [1:0] OP_ADDR = 2'h1;
    localparam logic [1:0] OP_DATA = 2'h2;
    localparam logic [1:0] OP_CMD = 2'h3;
    localparam logic [1:0] OP_FETCH = 2'h0;
    localparam logic [1:0] OP_UPPER = 2'h1;
    localparam logic [7:0] CMD_CHANNEL = 8'h00;
    localparam logic [7:0] CMD_RESET_COUNT = 8'h01;
    localparam logic [7:0] WR_SETUP = 8'h00;
    localparam logic [7:0] WR_AUX_SETUP = 8'h01;
    localparam logic [7:0] WR_ERRMASK = 8'h02;
    localparam logic [7:0] WR_SYNC = 8'h03;
    localparam logic [7:0] RD_MEASURE = 8'h00;
    localparam logic [7:0] RD_CONFIG = 8'h01;
    localparam logic [7:0] RD_COUNTER = 8'h07;
    localparam logic [7:0] SETUP_RESET = 8'h00;
    localparam logic [7:0] AUX_RESET = 8'h00;
    localparam logic [7:0] ERRMASK_RESET = 8'h07;
    localparam logic [7:0] SYNC_RESET = 8'h00;

    typedef struct packed {
        logic speed_counter;
        logic noise_filter;
        logic [2:0] edge_spacing_select;
        logic [2:0] interpolation_rate_select;
    } iosp_setup_type;

    typedef struct packed {
        logic [4:0] spare;
        logic zero_on_index;
        logic index_off;
        logic async_load;
    } iosp_aux_type;

    typedef struct packed {
        logic [3:0] spare;
        logic freeze_on_error;
        logic overspeed_quadrature_flag_en;
        logic overspeed_count_flag_en;
        logic sensor_en;
    } iosp_errmask_type;

    typedef struct packed {
        logic is_read;
        logic broadcast_select_low;
        logic [1:0] op;
        logic [3:0] target;
        logic [7:0] payload;
    } iosp_cmd_type;

    typedef struct packed {
        logic select_low;
        logic trigger;
        logic ref_pos;
        logic ref_neg;
        logic filter_pin;
        logic done_toggle;
        logic tx_bit;
        logic [3:0] chan;
    } iosp_pins_type;
endpackage

// ===== verilog/iosp_top.sv
// Purpose: counter, quadrature, index, error and serial slave back end
// Assumes: interpolator core gives one-cycle step pulses on clock
// Notes: serial bits shift on sclk; commands execute on clock
// Functional notes
// - position is 28-bit two's complement, zeroable
// - trigger edge captures position into two-entry buffer
// - index pulse at zero crossing while comparator active
// - configuration bit disables the index pulse
// - fault output on implausible input or overspeed
// - error mask enables sources, selects output response
// - eight interpolation rates, one edge per increment
// - quadrature periods equal one quarter of rate
// - minimum edge spacing 1 to 128 clocks
// - counter speed mode allows clock over 96
// - otherwise limit is 0.9 clock over rate times spacing
// - overspeed sets counter flag or quadrature flag
// - noise filter widens spacing to 2048 when slow
// - separate read/write shifters, hold and address registers
// - sixteen-bit words, byte writes, word reads
// - read data leaves during the following access
// - commands execute after the transfer ends
// - channel address learned from pins by command
// - slave only, never starts a transfer
// - open-drain data output doubles as ready
// - input sampled and hold shifted on rising edge
// - broadcast bit low addresses all channels on writes
// - data output low while fetch awaits its load
module iosp_top (
    // clocks and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic sclk,
    // serial port
    input wire logic sdi,
    input wire logic serial_select_low,
    input wire logic sdo_i,
    output logic sdo_o,
    output logic sdo_oe,
    // interpolator core and pins
    input wire logic step_up,
    input wire logic step_dn,
    input wire logic sensor_fault,
    input wire logic index_input_pos,
    input wire logic index_input_neg,
    input wire logic trigger_in,
    input wire logic edge_noise_filter_on,
    input wire logic [3:0] channel_id_pins,
    // results
    output logic quad_a,
    output logic quad_b,
    output logic index_pulse,
    output logic fault_output_low,
    output logic overspeed_count_flag,
    output logic overspeed_quadrature_flag,
    output logic [iosp_pkg::CNT_W-1:0] position
);
    typedef enum logic {S_IDLE, S_WAIT} iosp_state_type;

    function automatic logic [7:0] rate_of(input logic [2:0] sel);
        case (sel)
            3'h0: rate_of = 8'hA0;
            3'h1: rate_of = 8'h50;
            3'h2: rate_of = 8'h28;
            3'h3: rate_of = 8'h14;
            3'h4: rate_of = 8'hC8;
            3'h5: rate_of = 8'h64;
            3'h6: rate_of = 8'h32;
            default: rate_of = 8'h19;
        endcase
    endfunction

    // ceil(rate * spacing / 0.9) cycles per input period
    function automatic logic [19:0] period_limit(input logic [2:0] rs, input logic [2:0] ss);
        logic [23:0] prod;
        prod = 24'({rate_of(rs), 3'h0} + {2'h0, rate_of(rs), 1'h0}) << ss;
        period_limit = 20'((prod + 24'h8) / 24'h9);
    endfunction

    // ---------------- serial clock domain ----------------
    logic [1:0] lrst_q;
    logic [3:0] bit_cnt_q;
    logic [15:0] rx_sr_q;
    logic [15:0] rx_word_q;
    logic done_tgl_q;
    logic tx_bit_q;
    logic [15:0] tx_word_q;

    // rx word stays put until the next frame ends, long after pickup
    always_ff @(posedge sclk) begin
        lrst_q <= {lrst_q[0], rst};
        if (lrst_q[1]) begin
            bit_cnt_q <= 4'h0;
            rx_sr_q <= 16'h0000;
            rx_word_q <= 16'h0000;
            done_tgl_q <= 1'b0;
            tx_bit_q <= 1'b1;
        end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            rx_sr_q <= {rx_sr_q[14:0], sdi};
            tx_bit_q <= tx_word_q[4'hF - bit_cnt_q];
            if (bit_cnt_q == 4'hF) begin
                rx_word_q <= {rx_sr_q[14:0], sdi};
                done_tgl_q <= ~done_tgl_q;
            end
        end
    end

    // ---------------- oscillator domain ----------------
    iosp_pkg::iosp_pins_type pins_w, meta_q, sync_q;
    assign pins_w = '{select_low: serial_select_low, trigger: trigger_in,
                      ref_pos: index_input_pos, ref_neg: index_input_neg,
                      filter_pin: edge_noise_filter_on, done_toggle: done_tgl_q,
                      tx_bit: tx_bit_q, chan: channel_id_pins};

    always_ff @(posedge clock) begin
        meta_q <= pins_w;
        sync_q <= meta_q;
    end

    iosp_pkg::iosp_setup_type setup_q;
    iosp_pkg::iosp_aux_type aux_q;
    iosp_pkg::iosp_errmask_type mask_q;
    logic [7:0] sync_reg_q;
    logic [7:0] addr_q;
    logic [3:0] chan_q;
    logic [7:0] seq_q;
    logic done_prev_q;
    logic trig_prev_q;
    logic pend_q;
    iosp_pkg::iosp_cmd_type cmd_q;
    iosp_state_type state_q;
    logic [15:0] hold_q;
    logic [iosp_pkg::CNT_W-1:0] cnt_q, tb0_q, tb1_q;
    logic [1:0] tb_lvl_q;
    logic trgovl_q, senserr_q, overspeed_count_flag_q, overspeed_quadrature_flag_q;
    logic [7:0] ph_q;
    logic [19:0] per_q;
    logic [7:0] bk_q;
    logic [11:0] spc_q;
    logic [11:0] idle_q;
    logic [1:0] q2_q;
    logic idx_q, fault_q, sdo_oe_q;

    // decode and selection
    wire done_evt = sync_q.done_toggle ^ done_prev_q;
    wire exec = pend_q & sync_q.select_low;
    wire addressed = (~cmd_q.is_read & ~cmd_q.broadcast_select_low)
                     | (cmd_q.target == chan_q);
    wire do_wr = exec & addressed & ~cmd_q.is_read;
    wire do_rd = exec & addressed & cmd_q.is_read;
    wire wr_addr = do_wr & (cmd_q.op == iosp_pkg::OP_ADDR);
    wire wr_data = do_wr & (cmd_q.op == iosp_pkg::OP_DATA);
    wire wr_cmd = do_wr & (cmd_q.op == iosp_pkg::OP_CMD);
    wire learn_chan = wr_cmd & (cmd_q.payload == iosp_pkg::CMD_CHANNEL);
    wire clr_count = wr_cmd & (cmd_q.payload == iosp_pkg::CMD_RESET_COUNT);
    wire rd_fetch = do_rd & (cmd_q.op == iosp_pkg::OP_FETCH);
    wire rd_upper = do_rd & (cmd_q.op == iosp_pkg::OP_UPPER);
    wire load_ok = aux_q.async_load | (seq_q == sync_reg_q);
    wire do_load = (state_q == S_WAIT) & load_ok;
    wire trig_rise = sync_q.trigger & ~trig_prev_q;
    wire ref_active = sync_q.ref_pos & ~sync_q.ref_neg;
    wire up = step_up & ~step_dn;
    wire dn = step_dn & ~step_up;
    wire [7:0] rate = rate_of(setup_q.interpolation_rate_select);
    wire zero_pass = (up & (ph_q == rate - 8'h01)) | (dn & (ph_q == 8'h00));
    wire idx_fire = zero_pass & ref_active & ~aux_q.index_off;
    wire zero_cnt = clr_count | (aux_q.zero_on_index & idx_fire);
    wire frozen = (tb_lvl_q != 2'h0);
    wire pop = do_load & frozen & (addr_q == iosp_pkg::RD_MEASURE);

    // speed supervision
    wire [19:0] lim = period_limit(setup_q.interpolation_rate_select,
                                   setup_q.edge_spacing_select);
    wire counter_mode = setup_q.speed_counter | (lim <= iosp_pkg::SPEED_LIMIT_CYC);
    wire overspeed_count_flag_set = zero_pass & counter_mode & (per_q < iosp_pkg::SPEED_LIMIT_CYC);
    wire backlog_ovf = (bk_q[7] ? 8'(-bk_q) : bk_q) >= iosp_pkg::BACKLOG_LIMIT;
    wire overspeed_quadrature_flag_set = (zero_pass & ~counter_mode & (per_q < lim)) | backlog_ovf;
    wire err_any = (senserr_q & mask_q.sensor_en) | (overspeed_count_flag_q & mask_q.overspeed_count_flag_en)
                   | (overspeed_quadrature_flag_q & mask_q.overspeed_quadrature_flag_en);
    wire hold_out = mask_q.freeze_on_error & err_any;

    // quadrature edge pacing
    wire filter_on = setup_q.noise_filter | sync_q.filter_pin;
    wire slow = filter_on & (idle_q == iosp_pkg::IDLE_SATURATE);
    wire [11:0] spacing = slow ? iosp_pkg::FILTER_SPACING
                               : (12'h001 << setup_q.edge_spacing_select);
    wire emit = (spc_q == 12'h000) & (bk_q != 8'h00) & ~hold_out;
    wire emit_up = emit & ~bk_q[7];
    wire [7:0] bk_step = {{7{dn}}, up | dn};
    wire [7:0] bk_emit = emit ? (emit_up ? 8'hFF : 8'h01) : 8'h00;

    // read value selection
    wire [3:0] st_lo = {overspeed_count_flag_q, senserr_q, trgovl_q, frozen};
    wire [31:0] rd_measure = {frozen ? tb0_q : cnt_q, st_lo};
    wire [7:0] stat = {tb_lvl_q, overspeed_quadrature_flag_q, overspeed_count_flag_q, senserr_q, 3'h0};
    wire [31:0] rd_config = {mask_q, aux_q, setup_q, stat};
    wire [31:0] rd_counter = {cnt_q, 2'h0, senserr_q, overspeed_count_flag_q};
    wire [31:0] rd_value = (addr_q == iosp_pkg::RD_MEASURE) ? rd_measure
                         : (addr_q == iosp_pkg::RD_CONFIG) ? rd_config
                         : (addr_q == iosp_pkg::RD_COUNTER) ? rd_counter : 32'h0000_0000;

    // serial command handling
    always_ff @(posedge clock) begin
        done_prev_q <= sync_q.done_toggle;
        if (rst) begin
            pend_q <= 1'b0;
            cmd_q <= '0;
            state_q <= S_IDLE;
            addr_q <= 8'h00;
            chan_q <= 4'h0;
            setup_q <= iosp_pkg::SETUP_RESET;
            aux_q <= iosp_pkg::AUX_RESET;
            mask_q <= iosp_pkg::ERRMASK_RESET;
            sync_reg_q <= iosp_pkg::SYNC_RESET;
            tx_word_q <= 16'hFFFF;
            hold_q <= 16'h0000;
        end else begin
            if (done_evt) begin
                cmd_q <= rx_word_q;
                pend_q <= 1'b1;
            end else if (exec) begin
                pend_q <= 1'b0;
            end
            if (wr_addr | rd_fetch)
                addr_q <= cmd_q.payload;
            if (learn_chan)
                chan_q <= sync_q.chan;
            if (wr_data) begin
                case (addr_q)
                    iosp_pkg::WR_SETUP: setup_q <= cmd_q.payload;
                    iosp_pkg::WR_AUX_SETUP: aux_q <= cmd_q.payload;
                    iosp_pkg::WR_ERRMASK: mask_q <= cmd_q.payload;
                    iosp_pkg::WR_SYNC: sync_reg_q <= cmd_q.payload;
                    default: ;
                endcase
            end
            case (state_q)
                S_IDLE: if (rd_fetch) state_q <= S_WAIT;
                S_WAIT: if (load_ok) state_q <= S_IDLE;
                default: state_q <= S_IDLE;
            endcase
            // new read data is only staged between frames
            if (do_load) begin
                tx_word_q <= rd_value[15:0];
                hold_q <= rd_value[31:16];
            end else if (rd_upper) begin
                tx_word_q <= hold_q;
            end
        end
    end

    // open-drain output: low while waiting, else the shifted bit while selected
    always_ff @(posedge clock) begin
        if (rst)
            sdo_oe_q <= 1'b0;
        else
            sdo_oe_q <= (state_q == S_WAIT) | rd_fetch
                        | (~sync_q.select_low & ~sync_q.tx_bit);
    end

    // position, trigger buffer and flags
    always_ff @(posedge clock) begin
        trig_prev_q <= sync_q.trigger;
        if (rst) begin
            seq_q <= 8'h00;
            cnt_q <= '0;
            tb0_q <= '0;
            tb1_q <= '0;
            tb_lvl_q <= 2'h0;
            trgovl_q <= 1'b0;
            senserr_q <= 1'b0;
            overspeed_count_flag_q <= 1'b0;
            overspeed_quadrature_flag_q <= 1'b0;
        end else begin
            seq_q <= seq_q + 8'h01;
            if (zero_cnt)
                cnt_q <= '0;
            else
                cnt_q <= cnt_q + {{(iosp_pkg::CNT_W-1){dn}}, up | dn};
            // a capture in the pop cycle shifts in behind the remaining entry
            if (pop) begin
                tb0_q <= (tb_lvl_q == 2'h2) ? tb1_q : cnt_q;
                if (trig_rise)
                    tb1_q <= cnt_q;
                tb_lvl_q <= trig_rise ? tb_lvl_q : tb_lvl_q - 2'h1;
            end else if (trig_rise) begin
                case (tb_lvl_q)
                    2'h0: tb0_q <= cnt_q;
                    2'h1: tb1_q <= cnt_q;
                    default: ;
                endcase
                if (tb_lvl_q != 2'h2)
                    tb_lvl_q <= tb_lvl_q + 2'h1;
            end
            // set wins over the counter-reset clear
            trgovl_q <= (trgovl_q & ~clr_count) | (trig_rise & ~pop & (tb_lvl_q == 2'h2));
            senserr_q <= (senserr_q & ~clr_count) | sensor_fault;
            overspeed_count_flag_q <= (overspeed_count_flag_q & ~clr_count) | overspeed_count_flag_set;
            overspeed_quadrature_flag_q <= (overspeed_quadrature_flag_q & ~clr_count) | overspeed_quadrature_flag_set;
        end
    end

    // interpolation phase, period, pacing and outputs
    always_ff @(posedge clock) begin
        if (rst) begin
            ph_q <= 8'h00;
            per_q <= 20'h00000;
            bk_q <= 8'h00;
            spc_q <= 12'h000;
            idle_q <= 12'h000;
            q2_q <= 2'h0;
            idx_q <= 1'b0;
            fault_q <= 1'b1;
        end else begin
            if (up)
                ph_q <= (ph_q >= rate - 8'h01) ? 8'h00 : ph_q + 8'h01;
            else if (dn)
                ph_q <= (ph_q == 8'h00) ? rate - 8'h01 : ph_q - 8'h01;
            if (zero_pass)
                per_q <= 20'h00000;
            else if (per_q != 20'hFFFFF)
                per_q <= per_q + 20'h00001;
            idle_q <= emit ? 12'h000 // quiet time runs from the last edge, so noise cannot cut it
                    : (idle_q == iosp_pkg::IDLE_SATURATE) ? idle_q : idle_q + 12'h001;
            bk_q <= bk_q + bk_step + bk_emit;
            if (emit) begin
                q2_q <= emit_up ? {q2_q[0], ~q2_q[1]} : {~q2_q[0], q2_q[1]};
                spc_q <= spacing - 12'h001;
            end else if (spc_q != 12'h000) begin
                spc_q <= spc_q - 12'h001;
            end
            idx_q <= idx_fire;
            fault_q <= ~err_any;
        end
    end

    assign sdo_o = 1'b0;
    assign sdo_oe = sdo_oe_q;
    assign quad_a = q2_q[1];
    assign quad_b = q2_q[0];
    assign index_pulse = idx_q;
    assign fault_output_low = fault_q;
    assign overspeed_count_flag = overspeed_count_flag_q;
    assign overspeed_quadrature_flag = overspeed_quadrature_flag_q;
    assign position = cnt_q;

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_index_cause;
        index_pulse |-> $past(zero_pass) && $past(ref_active) && !$past(aux_q.index_off);
    endproperty
    a_index_cause: assert property (p_index_cause) else $error("index without cause");

    property p_index_off;
        aux_q.index_off [*2] |-> !index_pulse;
    endproperty
    a_index_off: assert property (p_index_off) else $error("index while disabled");

    property p_fault;
        err_any |=> !fault_output_low;
    endproperty
    a_fault: assert property (p_fault) else $error("fault output missing");

    property p_spacing;
        emit |=> (spc_q == $past(spacing) - 12'h001) && (!emit || spc_q == 12'h000);
    endproperty
    a_spacing: assert property (p_spacing) else $error("edge spacing wrong");

    property p_count_up;
        up && !zero_cnt |=> position == $past(position) + 28'h0000001;
    endproperty
    a_count_up: assert property (p_count_up) else $error("count not advanced");

    property p_trig_capture;
        trig_rise && tb_lvl_q == 2'h0 && !pop |=> tb_lvl_q == 2'h1 && tb0_q == $past(cnt_q);
    endproperty
    a_trig_capture: assert property (p_trig_capture) else $error("trigger not captured");

    property p_not_ready;
        state_q == S_WAIT |=> sdo_oe;
    endproperty
    a_not_ready: assert property (p_not_ready) else $error("ready shown while waiting");

    property p_chan_learn;
        learn_chan |=> chan_q == $past(sync_q.chan);
    endproperty
    a_chan_learn: assert property (p_chan_learn) else $error("channel not learned");

    property p_overspeed_count_flag;
        overspeed_count_flag_set |=> overspeed_count_flag;
    endproperty
    a_overspeed_count_flag: assert property (p_overspeed_count_flag) else $error("counter overspeed missed");

    property p_exec_after;
        done_evt && !sync_q.select_low ##1 !sync_q.select_low |-> pend_q && !exec;
    endproperty
    a_exec_after: assert property (p_exec_after) else $error("command ran in frame");
endmodule

// ===== dv/iosp_host.sv
// Purpose: serial master model that frames 16-bit words into the port
// Assumes: sclk idles low and runs only inside frames or during reset
// Notes: data line is open drain with a pull-up, ready when high
module iosp_host (
    // link
    output logic sclk,
    output logic sdi,
    output logic serial_select_low,
    // open-drain data line as seen on the wire
    input wire logic sdo_line
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sclk = 1'b0;
        sdi = 1'b0;
        serial_select_low = 1'b1;
    end

    // link side resets through its own clock, so clock it while deselected
    task automatic idle_clocks(input int n);
        repeat (n) begin
            #32 sclk = 1'b1;
            #32 sclk = 1'b0;
        end
    endtask

    // starts once ready or after 4000 polls without it; select low for exactly 16 clocks
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx, output logic ok);
        int n;
        n = 0;
        while (sdo_line !== 1'b1 && n < 4000) begin
            #8 n++;
        end
        ok = (n < 4000);
        serial_select_low = 1'b0;
        sdi = tx[15];
        #32;
        for (int i = 15; i >= 0; i--) begin
            sclk = 1'b1;
            #32 sclk = 1'b0;
            if (i > 0) sdi = tx[i-1];
            // sample late: the bit reaches the pin a few oscillator clocks after
            #30 rx[i] = sdo_line;
            #2;
        end
        serial_select_low = 1'b1;
        sdi = ~sdi;
        #64;
    endtask
endmodule

// ===== dv/testbench.sv
// Purpose: self-checking bench for the interpolator back end and serial port
// Assumes: channel pins strapped to 5, all fetches in async load mode
// Notes: quad edge spacing and index pulses are counted by monitors
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic sclk, sdi, select_low, sdo_o, sdo_oe, sdo_line;
    logic step_up = 1'b0, step_dn = 1'b0, sensor_fault = 1'b0, trigger_in = 1'b0;
    logic idx_pos = 1'b0, idx_neg = 1'b0, filter_on = 1'b0;
    logic [3:0] chan = 4'h5;
    logic quad_a, quad_b, index_pulse, fault_output_low, ovs_count, ovs_quad;
    logic [iosp_pkg::CNT_W-1:0] position;
    logic [1:0] quad_prev = 2'h0;
    logic [31:0] v;
    int fail_count = 0, checks_done = 0, edges = 0, gray_err = 0, idx_cnt = 0;
    int cyc = 0, last_edge = 0, min_gap = 0;

    always #4 clock = ~clock;
    assign sdo_line = sdo_oe ? sdo_o : 1'b1;

    iosp_host host_u (.sclk(sclk), .sdi(sdi), .serial_select_low(select_low),
        .sdo_line(sdo_line));

    iosp_top dut_u (.clock(clock), .rst(rst), .sclk(sclk), .sdi(sdi),
        .serial_select_low(select_low), .sdo_i(sdo_line), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
        .step_up(step_up), .step_dn(step_dn), .sensor_fault(sensor_fault),
        .index_input_pos(idx_pos), .index_input_neg(idx_neg), .trigger_in(trigger_in),
        .edge_noise_filter_on(filter_on), .channel_id_pins(chan), .quad_a(quad_a),
        .quad_b(quad_b), .index_pulse(index_pulse), .fault_output_low(fault_output_low),
        .overspeed_count_flag(ovs_count), .overspeed_quadrature_flag(ovs_quad),
        .position(position));

    // edge counting, gray-code and spacing watch on the quadrature pair
    always @(negedge clock) begin
        cyc++;
        if (index_pulse === 1'b1) idx_cnt++;
        if ({quad_a, quad_b} !== quad_prev) begin
            edges++;
            if (^({quad_a, quad_b} ^ quad_prev) !== 1'b1) gray_err++;
            if (cyc - last_edge < min_gap) min_gap = cyc - last_edge;
            last_edge = cyc;
            quad_prev = {quad_a, quad_b};
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic frame(input logic [15:0] w, output logic [15:0] rx);
        logic ok;
        host_u.xfer(w, rx, ok);
        checks_done++;
        if (!ok) begin
            fail_count++;
            $display("FAIL ready expected 1 seen 0");
            finish_test();
        end
    endtask

    // byte write: address word then data word; bcl low means all channels
    task automatic wreg(input logic [3:0] t, input logic bcl, input logic [7:0] a, d);
        logic [15:0] rx;
        frame({1'b0, bcl, iosp_pkg::OP_ADDR, t, a}, rx);
        frame({1'b0, bcl, iosp_pkg::OP_DATA, t, d}, rx);
    endtask

    task automatic cmd(input logic [7:0] c);
        logic [15:0] rx;
        frame({1'b0, 1'b1, iosp_pkg::OP_CMD, 4'h5, c}, rx);
    endtask

    // fetch, then low word with upper request, then upper word
    task automatic rd32(input logic [7:0] a, output logic [31:0] val);
        logic [15:0] lo, hi;
        frame({1'b1, 1'b1, iosp_pkg::OP_FETCH, 4'h5, a}, lo);
        frame({1'b1, 1'b1, iosp_pkg::OP_UPPER, 4'h5, 8'h00}, lo);
        frame({1'b1, 1'b1, 2'h2, 4'h5, 8'h00}, hi);
        val = {hi, lo};
    endtask

    task automatic steps(input int n, input logic up, input int gap);
        repeat (n) begin
            @(negedge clock);
            step_up = up;
            step_dn = !up;
            @(negedge clock);
            step_up = 1'b0;
            step_dn = 1'b0;
            repeat (gap) @(negedge clock);
        end
    endtask

    task automatic pulse(ref logic s);
        @(negedge clock);
        s = 1'b1;
        repeat (2) @(negedge clock);
        s = 1'b0;
        repeat (8) @(negedge clock);
    endtask

    initial begin
        logic [15:0] rx;
        host_u.idle_clocks(4);
        repeat (3) @(negedge clock);
        rst = 1'b0;
        // link side leaves reset only after two more of its own edges
        host_u.idle_clocks(2);
        repeat (4) @(negedge clock);
        check("reset pins", 32'h04, {quad_a, quad_b, index_pulse, fault_output_low,
            ovs_count, ovs_quad});
        check("reset position", 32'h0, position);
        check("reset line", 32'h1, sdo_line);
        frame({1'b0, 1'b0, iosp_pkg::OP_CMD, 4'h0, iosp_pkg::CMD_CHANNEL}, rx);
        wreg(4'h5, 1'b1, iosp_pkg::WR_AUX_SETUP, 8'h01);
        wreg(4'h3, 1'b1, iosp_pkg::WR_ERRMASK, 8'h00);
        rd32(iosp_pkg::RD_CONFIG, v);
        check("config", 32'h07010000, v);
        edges = 0;
        gray_err = 0;
        steps(10, 1'b1, 3);
        steps(13, 1'b0, 3);
        repeat (8) @(negedge clock);
        check("position", 32'h0FFFFFFD, position);
        check("quad edges", 32'd23, edges);
        check("gray", 32'd0, gray_err);
        rd32(iosp_pkg::RD_COUNTER, v);
        check("counter read", 32'hFFFFFFD0, v);
        pulse(trigger_in);
        steps(4, 1'b1, 3);
        rd32(iosp_pkg::RD_MEASURE, v);
        check("trigger value", 32'hFFFFFFD1, v);
        rd32(iosp_pkg::RD_MEASURE, v);
        check("live value", 32'h00000010, v);
        idx_pos = 1'b1;
        idx_cnt = 0;
        steps(160, 1'b1, 2);
        check("index one period", 32'd1, idx_cnt);
        wreg(4'h5, 1'b1, iosp_pkg::WR_AUX_SETUP, 8'h03);
        idx_cnt = 0;
        steps(160, 1'b1, 2);
        check("index disabled", 32'd0, idx_cnt);
        pulse(sensor_fault);
        check("fault set", 32'h0, fault_output_low);
        cmd(iosp_pkg::CMD_RESET_COUNT);
        check("cleared", 32'h1, {position, fault_output_low});
        wreg(4'h5, 1'b1, iosp_pkg::WR_ERRMASK, 8'h06);
        pulse(sensor_fault);
        check("fault masked", 32'h1, fault_output_low);
        wreg(4'h0, 1'b0, iosp_pkg::WR_SETUP, 8'h18);
        edges = 0;
        min_gap = 100000;
        steps(6, 1'b1, 0);
        repeat (60) @(negedge clock);
        check("spaced edges", 32'd6, edges);
        check("spacing 8", 32'h1, min_gap >= 8);
        cmd(iosp_pkg::CMD_RESET_COUNT);
        wreg(4'h5, 1'b1, iosp_pkg::WR_SETUP, 8'h0C);
        steps(220, 1'b1, 1);
        check("no overspeed", 32'h0, {ovs_count, ovs_quad});
        steps(220, 1'b1, 0);
        check("quad overspeed", 32'h1, {ovs_count, ovs_quad});
        cmd(iosp_pkg::CMD_RESET_COUNT);
        wreg(4'h5, 1'b1, iosp_pkg::WR_SETUP, 8'h83);
        steps(60, 1'b1, 0);
        check("count overspeed", 32'h1, ovs_count);
        check("speed fault", 32'h0, fault_output_low);
        cmd(iosp_pkg::CMD_RESET_COUNT);
        wreg(4'h5, 1'b1, iosp_pkg::WR_SETUP, 8'h00);
        filter_on = 1'b1;
        repeat (2100) @(negedge clock);
        edges = 0;
        min_gap = 100000;
        steps(2, 1'b1, 0);
        repeat (4200) @(negedge clock);
        check("filter edges", 32'd2, edges);
        check("filter gap", 32'h1, min_gap >= 2048);
        finish_test();
    end
endmodule
